// ---- src/list_command_a_pkg.sv ----
// Purpose: shared constants and types for the set-point and status block
// Assumes: commands arrive already decoded as a code plus operands
// Notes:   values are in fixed-point engineering units chosen by firmware
package list_command_a_pkg;

  // ==========================================================================
  // command codes
  typedef enum logic [4:0] {
    CMD_NONE      = 5'h00,
    CMD_CURR      = 5'h01,
    CMD_VOLT      = 5'h02,
    CMD_POW       = 5'h03,
    CMD_RES       = 5'h04,
    CMD_LIST      = 5'h05,
    CMD_LOW_TRIP  = 5'h06,
    CMD_HIGH_TRIP = 5'h07,
    CMD_PSLEW_R   = 5'h08,
    CMD_PSLEW_F   = 5'h09,
    CMD_PSLEW_B   = 5'h0A,
    CMD_VSLEW_R   = 5'h0B,
    CMD_VSLEW_F   = 5'h0C,
    CMD_VSLEW_B   = 5'h0D,
    CMD_CLS       = 5'h0E,
    CMD_EVT_EN    = 5'h0F,
    CMD_EVT_RD    = 5'h10,
    CMD_OPC       = 5'h11,
    CMD_RST       = 5'h12,
    CMD_SRQ_EN    = 5'h13,
    CMD_SBYTE_RD  = 5'h14,
    CMD_IDN       = 5'h15
  } cmd_code_t;

  // ==========================================================================
  // widths, limits and defaults
  localparam int VAL_W = 16;
  localparam logic [VAL_W-1:0] SET_MIN   = 16'h0000;
  localparam logic [VAL_W-1:0] SET_MAX   = 16'hFFFF;
  localparam logic [VAL_W-1:0] SLEW_MIN  = 16'h0001;
  localparam logic [VAL_W-1:0] SLEW_MAX  = 16'h03E8;
  localparam int SLEW_STEP_LOG2 = 3;
  localparam int TRIP_SAMPLES   = 4;

  // ==========================================================================
  // event status, status byte and questionable word bit positions
  localparam int EV_OPC = 0;
  localparam int EV_QYE = 2;
  localparam int EV_DDE = 3;
  localparam int EV_EXE = 4;
  localparam int EV_CME = 5;
  localparam int EV_PON = 7;
  localparam logic [7:0] EV_USED_MASK = 8'hBD;
  localparam int SB_QUES = 3;
  localparam int SB_MAV  = 4;
  localparam int SB_ESB  = 5;
  localparam int SB_RQS  = 6;
  localparam logic [7:0] SRQ_USED_MASK = 8'h38;
  localparam int QS_SOFT = 11;
  localparam int QS_HARD = 12;
  localparam int QS_HI_TRIP = 2;
  localparam logic [15:0] QS_SOFT_MASK = 16'h000E;
  localparam logic [15:0] QS_HARD_MASK = 16'h0071;

  // ==========================================================================
  // command request carrier
  typedef struct packed {
    cmd_code_t        code;
    logic [VAL_W-1:0] arg0;
    logic [VAL_W-1:0] arg1;
    logic [VAL_W-1:0] arg2;
    logic [VAL_W-1:0] arg3;
  } cmd_req_t;

  // trip settings carrier
  typedef struct packed {
    logic [VAL_W-1:0] low_lim;
    logic [VAL_W-1:0] high_lim;
  } trip_lim_t;

endpackage : list_command_a_pkg

// ---- src/trip_detect.sv ----
// Purpose: consecutive-sample voltage trip comparator
// Assumes: one voltage sample per sample_valid_in pulse
// Notes:   fault stays latched until clear_in
`timescale 1ns/10ps
module trip_detect
  import list_command_a_pkg::*;
#(
  parameter int SAMPLES = TRIP_SAMPLES,
  parameter bit ABOVE   = 1'b0
) (
  // clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             reset_n_in,
  // sample and limit
  input  wire logic             sample_valid_in,
  input  wire logic [VAL_W-1:0] sample_in,
  input  wire logic [VAL_W-1:0] limit_in,
  input  wire logic             clear_in,
  // latched fault
  output logic                  fault_out
);

  initial begin
    if (SAMPLES < 1 || SAMPLES > 255) $error("trip_detect: bad SAMPLES");
  end

  logic [7:0] run_ff;
  logic       beyond;

  assign beyond = ABOVE ? (sample_in > limit_in) : (sample_in < limit_in);

  // count consecutive beyond-limit samples, latch fault at threshold
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      run_ff    <= 8'h00;
      fault_out <= 1'b0;
    end else begin
      if (sample_valid_in) begin
        if (!beyond) begin
          run_ff <= 8'h00;
        end else if (run_ff < 8'(SAMPLES)) begin
          run_ff <= run_ff + 8'h01;
        end
      end
      if (sample_valid_in && beyond && run_ff == 8'(SAMPLES - 1)) begin
        fault_out <= 1'b1;
      end else if (clear_in) begin
        fault_out <= 1'b0;
      end
    end
  end

endmodule : trip_detect

// ---- src/list_command_a_status.sv ----
// Purpose: set-point, trip limit, slew and status reporting register bank
// Assumes: commands decoded upstream, one per cmd_valid_in pulse
// Notes:   answers come one cycle after the command is taken
`timescale 1ns/10ps
module list_command_a_status
  import list_command_a_pkg::*;
#(
  parameter int          TRIP_N   = TRIP_SAMPLES,
  parameter logic [15:0] IDN_MAKER  = 16'h1234, // arbitrary value
  parameter logic [15:0] IDN_MODEL  = 16'h0001, // arbitrary value
  parameter logic [15:0] IDN_SERIAL = 16'h0002, // arbitrary value
  parameter logic [15:0] IDN_FW     = 16'h0003  // arbitrary value
) (
  // clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             reset_n_in,
  // decoded command port
  input  wire logic             cmd_valid_in,
  input  wire cmd_req_t         cmd_in,
  input  wire logic             cmd_busy_in,
  // error event pulses from the parser
  input  wire logic             err_query_in,
  input  wire logic             err_device_in,
  input  wire logic             err_exec_in,
  input  wire logic             err_command_in,
  input  wire logic             msg_avail_in,
  input  wire logic [15:0]      ques_live_in,
  // voltage samples
  input  wire logic             sample_valid_in,
  input  wire logic [VAL_W-1:0] volt_sample_in,
  input  wire logic             fault_clear_in,
  // answers
  output logic                  resp_valid_out,
  output logic [63:0]           resp_data_out,
  output logic                  err_queue_clr_out,
  // settings toward regulation
  output logic [VAL_W-1:0]      curr_set_out,
  output logic [VAL_W-1:0]      volt_set_out,
  output logic [VAL_W-1:0]      pow_set_out,
  output logic [VAL_W-1:0]      res_set_out,
  output logic [VAL_W-1:0]      pslew_rise_out,
  output logic [VAL_W-1:0]      pslew_fall_out,
  output logic [VAL_W-1:0]      vslew_rise_out,
  output logic [VAL_W-1:0]      vslew_fall_out,
  output trip_lim_t             trip_lim_out,
  // protection and status
  output logic                  under_voltage_trip_out,
  output logic                  over_voltage_trip_out,
  output logic                  input_disconnect_out,
  output logic [15:0]           ques_word_out,
  output logic [7:0]            status_byte_out,
  output logic                  srq_out
);

  initial begin
    if (TRIP_N < 1 || TRIP_N > 255) $error("list_command_a_status: bad TRIP_N");
  end

  // ==========================================================================
  // command decode helpers
  logic take;
  logic is_rst;
  logic [7:0] event_status_ff;
  logic [7:0] event_enable_mask_ff;
  logic [7:0] service_request_enable_ff;
  logic       opc_pending_ff;
  logic       soft_fault_summary;
  logic       hard_fault_summary;
  logic       event_summary;
  logic [7:0] nxt_event_status;

  assign take   = cmd_valid_in;
  assign is_rst = take && cmd_in.code == CMD_RST;

  // clamp, round to nearest step; minimum wins below its midpoint
  function automatic logic [VAL_W-1:0] slew_fit(input logic [VAL_W-1:0] v);
    logic [VAL_W:0]   r;
    logic [VAL_W-1:0] q;
    r = {1'b0, v} + (VAL_W+1)'(1 << (SLEW_STEP_LOG2 - 1));
    q = VAL_W'((r >> SLEW_STEP_LOG2) << SLEW_STEP_LOG2);
    if (v <= SLEW_MIN || {1'b0, v, 1'b0} < (VAL_W+2)'(SLEW_MIN)
        + (VAL_W+2)'(1 << SLEW_STEP_LOG2)) begin
      slew_fit = SLEW_MIN;
    end else if (v >= SLEW_MAX || q > SLEW_MAX) begin
      slew_fit = SLEW_MAX;
    end else if (q < SLEW_MIN) begin
      slew_fit = SLEW_MIN;
    end else begin
      slew_fit = q;
    end
  endfunction : slew_fit

  // ==========================================================================
  // set-points
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      curr_set_out <= SET_MIN;
      volt_set_out <= SET_MIN;
      pow_set_out  <= SET_MIN;
      res_set_out  <= SET_MIN;
    end else if (is_rst) begin
      curr_set_out <= SET_MIN;
      volt_set_out <= SET_MIN;
      pow_set_out  <= SET_MIN;
      res_set_out  <= SET_MIN;
    end else if (take) begin
      case (cmd_in.code)
        CMD_CURR: curr_set_out <= cmd_in.arg0;
        CMD_VOLT: volt_set_out <= cmd_in.arg0;
        CMD_POW:  pow_set_out  <= cmd_in.arg0;
        CMD_RES:  res_set_out  <= cmd_in.arg0;
        CMD_LIST: begin
          curr_set_out <= cmd_in.arg0;
          volt_set_out <= cmd_in.arg1;
          pow_set_out  <= cmd_in.arg2;
          res_set_out  <= cmd_in.arg3;
        end
        default: ;
      endcase
    end
  end

  // slew rates
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pslew_rise_out <= SLEW_MAX;
      pslew_fall_out <= SLEW_MAX;
      vslew_rise_out <= SLEW_MAX;
      vslew_fall_out <= SLEW_MAX;
    end else if (is_rst) begin
      pslew_rise_out <= SLEW_MAX;
      pslew_fall_out <= SLEW_MAX;
      vslew_rise_out <= SLEW_MAX;
      vslew_fall_out <= SLEW_MAX;
    end else if (take) begin
      case (cmd_in.code)
        CMD_PSLEW_R: pslew_rise_out <= slew_fit(cmd_in.arg0);
        CMD_PSLEW_F: pslew_fall_out <= slew_fit(cmd_in.arg0);
        CMD_PSLEW_B: begin
          pslew_rise_out <= slew_fit(cmd_in.arg0);
          pslew_fall_out <= slew_fit(cmd_in.arg1);
        end
        CMD_VSLEW_R: vslew_rise_out <= slew_fit(cmd_in.arg0);
        CMD_VSLEW_F: vslew_fall_out <= slew_fit(cmd_in.arg0);
        CMD_VSLEW_B: begin
          vslew_rise_out <= slew_fit(cmd_in.arg0);
          vslew_fall_out <= slew_fit(cmd_in.arg1);
        end
        default: ;
      endcase
    end
  end

  // trip limits
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      trip_lim_out <= '{default: SET_MAX};
    end else if (is_rst) begin
      trip_lim_out <= '{default: SET_MAX};
    end else if (take && cmd_in.code == CMD_LOW_TRIP) begin
      trip_lim_out.low_lim <= cmd_in.arg0;
    end else if (take && cmd_in.code == CMD_HIGH_TRIP) begin
      trip_lim_out.high_lim <= cmd_in.arg0;
    end
  end

  // ==========================================================================
  // voltage trip detectors
  trip_detect #(.SAMPLES(TRIP_N), .ABOVE(1'b0)) low_trip_det (
    .ref_clk_in      (ref_clk_in),
    .reset_n_in      (reset_n_in),
    .sample_valid_in (sample_valid_in),
    .sample_in       (volt_sample_in),
    .limit_in        (trip_lim_out.low_lim),
    .clear_in        (fault_clear_in),
    .fault_out       (under_voltage_trip_out)
  );

  trip_detect #(.SAMPLES(TRIP_N), .ABOVE(1'b1)) high_trip_det (
    .ref_clk_in      (ref_clk_in),
    .reset_n_in      (reset_n_in),
    .sample_valid_in (sample_valid_in),
    .sample_in       (volt_sample_in),
    .limit_in        (trip_lim_out.high_lim),
    .clear_in        (fault_clear_in),
    .fault_out       (over_voltage_trip_out)
  );

  assign input_disconnect_out = under_voltage_trip_out
                              | over_voltage_trip_out;

  // ==========================================================================
  // questionable word with fault summaries
  assign soft_fault_summary = |(ques_live_in & QS_SOFT_MASK);
  assign hard_fault_summary = |(ques_live_in & QS_HARD_MASK);
  always_comb begin
    ques_word_out          = ques_live_in;
    ques_word_out[QS_HI_TRIP] = ques_live_in[QS_HI_TRIP]
                              | over_voltage_trip_out;
    ques_word_out[QS_SOFT] = soft_fault_summary | over_voltage_trip_out;
    ques_word_out[QS_HARD] = hard_fault_summary;
  end

  // ==========================================================================
  // event status: sets win over clears
  always_comb begin
    nxt_event_status = event_status_ff;
    if (take && (cmd_in.code == CMD_CLS || cmd_in.code == CMD_EVT_RD)) begin
      nxt_event_status = 8'h00;
    end
    if (take && cmd_in.code == CMD_OPC) begin
      nxt_event_status[EV_OPC] = 1'b0;
    end
    if (opc_pending_ff && !cmd_busy_in) begin
      nxt_event_status[EV_OPC] = 1'b1;
    end
    if (err_query_in)   nxt_event_status[EV_QYE] = 1'b1;
    if (err_device_in)  nxt_event_status[EV_DDE] = 1'b1;
    if (err_exec_in)    nxt_event_status[EV_EXE] = 1'b1;
    if (err_command_in) nxt_event_status[EV_CME] = 1'b1;
    nxt_event_status = nxt_event_status & EV_USED_MASK;
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      event_status_ff <= 8'(1 << EV_PON); // power-on bit
    end else begin
      event_status_ff <= nxt_event_status;
    end
  end

  // op-complete wait
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      opc_pending_ff <= 1'b0;
    end else if (take && cmd_in.code == CMD_OPC) begin
      opc_pending_ff <= 1'b1;
    end else if (!cmd_busy_in) begin
      opc_pending_ff <= 1'b0;
    end
  end

  // enable masks, no reset-command default
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      event_enable_mask_ff      <= 8'h00;
      service_request_enable_ff <= 8'h00;
    end else if (take && cmd_in.code == CMD_EVT_EN) begin
      event_enable_mask_ff <= cmd_in.arg0[7:0] & EV_USED_MASK;
    end else if (take && cmd_in.code == CMD_SRQ_EN) begin
      service_request_enable_ff <= cmd_in.arg0[7:0] & SRQ_USED_MASK;
    end
  end

  // ==========================================================================
  // status byte, live from its sources
  assign event_summary = |(event_status_ff & event_enable_mask_ff);
  always_comb begin
    status_byte_out          = 8'h00;
    status_byte_out[SB_QUES] = |ques_word_out;
    status_byte_out[SB_MAV]  = msg_avail_in;
    status_byte_out[SB_ESB]  = event_summary;
    status_byte_out[SB_RQS]  = |(status_byte_out & service_request_enable_ff);
  end
  assign srq_out = status_byte_out[SB_RQS];

  // ==========================================================================
  // answers
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      resp_valid_out    <= 1'b0;
      resp_data_out     <= 64'h0;
      err_queue_clr_out <= 1'b0;
    end else begin
      resp_valid_out    <= 1'b0;
      err_queue_clr_out <= take && cmd_in.code == CMD_CLS;
      if (take) begin
        case (cmd_in.code)
          CMD_EVT_RD: begin
            resp_valid_out <= 1'b1;
            resp_data_out  <= {56'h0, event_status_ff};
          end
          CMD_SBYTE_RD: begin
            resp_valid_out <= 1'b1;
            resp_data_out  <= {56'h0, status_byte_out};
          end
          CMD_IDN: begin
            resp_valid_out <= 1'b1;
            resp_data_out  <= {IDN_MAKER, IDN_MODEL,
                               IDN_SERIAL, IDN_FW};
          end
          default: ;
        endcase
      end
    end
  end

  // ==========================================================================
  // checks
  evt_read_clear_a: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    (take && cmd_in.code == CMD_EVT_RD && !err_query_in && !err_device_in
     && !err_exec_in && !err_command_in && !opc_pending_ff)
    |=> event_status_ff == 8'h00 && resp_valid_out)
    else $error("event status not cleared by read");

  srq_zero_a: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    service_request_enable_ff == 8'h00 |-> !srq_out)
    else $error("service request with zero enable");

  esb_sum_a: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    status_byte_out[SB_ESB] == |(event_status_ff & event_enable_mask_ff))
    else $error("event summary mismatch");

  slew_range_a: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    pslew_rise_out >= SLEW_MIN && pslew_rise_out <= SLEW_MAX
    && vslew_fall_out >= SLEW_MIN && vslew_fall_out <= SLEW_MAX)
    else $error("slew out of range");

  list_load_a: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    take && cmd_in.code == CMD_LIST
    |=> curr_set_out == $past(cmd_in.arg0) && res_set_out == $past(cmd_in.arg3))
    else $error("list load order wrong");

  rst_default_a: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    is_rst |=> pslew_fall_out == SLEW_MAX && volt_set_out == SET_MIN
    && trip_lim_out.low_lim == SET_MAX)
    else $error("reset defaults wrong");

  opc_clear_a: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    take && cmd_in.code == CMD_OPC && cmd_busy_in
    ##1 cmd_busy_in |-> !event_status_ff[EV_OPC])
    else $error("done bit not cleared");

  stb_layout_a: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    (status_byte_out & 8'h87) == 8'h00
    && srq_out == |(status_byte_out & service_request_enable_ff))
    else $error("status byte layout wrong");

endmodule : list_command_a_status

// ---- dv/remote_host.sv ----
// Purpose: remote controller model issuing decoded commands
// Assumes: one command per call, launched just after a rising edge
// Notes:   operands are scrambled once the command has been taken
`timescale 1ns/10ps
module remote_host
  import list_command_a_pkg::*;
(
  // clock
  input  wire logic ref_clk_in,
  // command toward the block
  output logic      cmd_valid_out,
  output cmd_req_t  cmd_out
);
  // ==========================================================================
  // command issue
  initial begin
    cmd_valid_out = 1'b0;
    cmd_out       = '0;
  end

  // one-cycle pulse; returns 1 time unit after the edge that takes it
  task automatic send(input cmd_code_t c, input logic [15:0] a0,
                      input logic [15:0] a1, input logic [15:0] a2,
                      input logic [15:0] a3);
    @(posedge ref_clk_in);
    cmd_valid_out <= 1'b1;
    cmd_out       <= '{c, a0, a1, a2, a3};
    @(posedge ref_clk_in);
    cmd_valid_out <= 1'b0;
    cmd_out       <= ~cmd_out;  // no stale operands left standing
    #1;
  endtask : send
endmodule : remote_host

// ---- dv/list_command_a_status_tb.sv ----
// Purpose: self-checking bench for the set-point and status bank
// Assumes: host model issues commands, bench drives every other input
// Notes:   integer model predicts every output but resp_d and eq_clr after each step
`timescale 1ns/10ps
module list_command_a_status_tb
  import list_command_a_pkg::*;
;
  localparam int          TN = 4;
  localparam logic [15:0] MK = 16'hC0DE;  // arbitrary value
  localparam logic [15:0] MD = 16'h0011;  // arbitrary value
  localparam logic [15:0] SN = 16'h0022;  // arbitrary value
  localparam logic [15:0] FW = 16'h0033;  // arbitrary value
  // ==========================================================================
  // stimulus, outputs and model state
  logic        clk = 1'b0, rst_n = 1'b0, busy = 1'b0, mav = 1'b0;
  logic        smp_v = 1'b0, fclr = 1'b0;
  logic [3:0]  err = 4'h0;
  logic [15:0] ques = 16'h0000, smp = 16'h0000;
  logic        cv, resp_v, eq_clr, uvf, ovf, disc, srq;
  cmd_req_t    cmd;
  logic [63:0] resp_d;
  logic [15:0] cur, vol, pw, rs, psr, psf, vsr, vsf, qw;
  logic [7:0]  sb;
  trip_lim_t   tl;
  int          fails = 0, samples_checked = 0, seed = 84246;
  int          s[4], sp[4], lo_lim, hi_lim, event_status, event_enable_mask, service_request_enable, rv_m, uv_m, ov_m;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  remote_host host_u (.ref_clk_in(clk), .cmd_valid_out(cv), .cmd_out(cmd));

  list_command_a_status #(.TRIP_N(TN), .IDN_MAKER(MK), .IDN_MODEL(MD),
                    .IDN_SERIAL(SN), .IDN_FW(FW)) dut_u (
    .ref_clk_in(clk), .reset_n_in(rst_n), .cmd_valid_in(cv),
    .cmd_in(cmd), .cmd_busy_in(busy), .err_query_in(err[0]),
    .err_device_in(err[1]), .err_exec_in(err[2]),
    .err_command_in(err[3]), .msg_avail_in(mav), .ques_live_in(ques),
    .sample_valid_in(smp_v), .volt_sample_in(smp), .fault_clear_in(fclr),
    .resp_valid_out(resp_v), .resp_data_out(resp_d),
    .err_queue_clr_out(eq_clr), .curr_set_out(cur), .volt_set_out(vol),
    .pow_set_out(pw), .res_set_out(rs), .pslew_rise_out(psr),
    .pslew_fall_out(psf), .vslew_rise_out(vsr), .vslew_fall_out(vsf),
    .trip_lim_out(tl), .under_voltage_trip_out(uvf),
    .over_voltage_trip_out(ovf), .input_disconnect_out(disc),
    .ques_word_out(qw), .status_byte_out(sb), .srq_out(srq));

  // ==========================================================================
  // model helpers
  function automatic int snap(int v);
    int st;
    int q;
    st = 1 << SLEW_STEP_LOG2;
    q = ((v + st / 2) / st) * st;
    if (q < int'(SLEW_MIN)) q = int'(SLEW_MIN);
    if (2 * v < int'(SLEW_MIN) + st) q = int'(SLEW_MIN); // min is nearer
    if (q > int'(SLEW_MAX)) q = int'(SLEW_MAX);
    return q;
  endfunction : snap

  task automatic set_defaults();
    for (int k = 0; k < 4; k++) begin
      s[k] = int'(SLEW_MAX);
      sp[k] = int'(SET_MIN);
    end
    lo_lim = int'(SET_MAX);
    hi_lim = int'(SET_MAX);
  endtask : set_defaults

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up

  task automatic cmd_do(cmd_code_t c, int a0 = 0, int a1 = 0, int a2 = 0,
                        int a3 = 0);
    host_u.send(c, a0[15:0], a1[15:0], a2[15:0], a3[15:0]);
    rv_m = (c == CMD_EVT_RD || c == CMD_SBYTE_RD || c == CMD_IDN) ? 1 : 0;
  endtask : cmd_do

  // one pulse on a strobe-like input group
  task automatic samp(int v);
    @(posedge clk);
    smp_v <= 1'b1;
    smp   <= v[15:0];
    @(posedge clk);
    smp_v <= 1'b0;
    smp   <= ~smp;
    #1;
    rv_m = 0;
  endtask : samp

  task automatic pulse_err(int k);
    @(posedge clk);
    err <= 4'h1 << k;
    @(posedge clk);
    err <= 4'h0;
    #1;
    event_status |= 4 << k;
    rv_m = 0;
  endtask : pulse_err

  // compare every output except resp_d and eq_clr with the model
  task automatic chk_all();
    int q;
    int b;
    q = ques | (ov_m ? 1 << QS_HI_TRIP : 0);
    if ((q & QS_SOFT_MASK) != 0) q |= 1 << QS_SOFT;
    if ((q & QS_HARD_MASK) != 0) q |= 1 << QS_HARD;
    b = (((event_status & event_enable_mask) != 0) ? 32 : 0) | (mav ? 16 : 0) | ((q != 0) ? 8 : 0);
    if ((b & service_request_enable) != 0) b |= 64;
    chk(psr, s[0]);
    chk(psf, s[1]);
    chk(vsr, s[2]);
    chk(vsf, s[3]);
    chk(cur, sp[0]);
    chk(vol, sp[1]);
    chk(pw, sp[2]);
    chk(rs, sp[3]);
    chk(tl, {lo_lim[15:0], hi_lim[15:0]});
    chk(uvf, uv_m);
    chk(ovf, ov_m);
    chk(disc, uv_m | ov_m);
    chk(qw, q);
    chk(sb, b);
    chk(srq, b[6]);
    chk(resp_v, rv_m);
  endtask : chk_all

  // ==========================================================================
  // test sequence
  initial begin : main
    int v0;
    int v1;
    int r[4];
    int k;
    cmd_code_t cs[6];
    int ed[6];
    cs = '{CMD_PSLEW_B, CMD_VSLEW_B, CMD_PSLEW_R, CMD_PSLEW_F, CMD_VSLEW_R,
           CMD_VSLEW_F};
    ed = '{0, 3, 4, 997, 1001, 65535};
    set_defaults();
    event_status = 8'h80;
    {event_enable_mask, service_request_enable, rv_m, uv_m, ov_m} = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk_all();
    $display("reset defaults test done");
    // slew pairs and singles, edge values then random
    for (k = 0; k < 12; k++) begin
      v0 = (k < 6) ? ed[k] : ($random(seed) & 16'h07FF);
      v1 = $random(seed) & 16'h07FF;
      cmd_do(cs[k % 6], v0, v1);
      if (k % 6 == 0) {s[0], s[1]} = {snap(v0), snap(v1)};
      else if (k % 6 == 1) {s[2], s[3]} = {snap(v0), snap(v1)};
      else s[k % 6 - 2] = snap(v0);
      chk_all();
    end
    $display("slew test done");
    // list command then single set-points
    for (k = 5; k >= 1; k--) begin
      foreach (r[i]) r[i] = $random(seed) & 16'hFFFF;
      cmd_do(cmd_code_t'(k), r[0], r[1], r[2], r[3]);
      if (k == 5) sp = r;
      else sp[k - 1] = r[0];
      chk_all();
    end
    cmd_do(CMD_LOW_TRIP, 100);
    cmd_do(CMD_HIGH_TRIP, 500);
    {lo_lim, hi_lim} = {32'd100, 32'd500};
    chk_all();
    $display("set-point test done");
    // broken run of low samples must not trip
    for (k = 0; k < TN - 1; k++) samp(50);
    samp(300);
    for (k = 0; k < TN; k++) begin
      samp(50);
      uv_m = (k == TN - 1) ? 1 : 0;
      chk_all();
    end
    for (k = 0; k < TN; k++) begin
      samp(600);
      ov_m = (k == TN - 1) ? 1 : 0;
      chk_all();
    end
    @(posedge clk);
    fclr <= 1'b1;
    @(posedge clk);
    fclr <= 1'b0;
    #1;
    {uv_m, ov_m} = '0;
    chk_all();
    $display("trip test done");
    // event register, masks and summary bits
    cmd_do(CMD_EVT_RD);
    chk(resp_d, 64'h80);
    event_status = 0;
    cmd_do(CMD_EVT_EN, 'hFF);
    event_enable_mask = 'hBD;
    chk_all();
    for (k = 0; k < 4; k++) begin
      pulse_err(k);
      chk_all();
    end
    cmd_do(CMD_SRQ_EN, 'hFF);
    service_request_enable = 'h38;
    @(posedge clk);
    mav  <= 1'b1;
    ques <= 16'h0020;
    #1;
    chk_all();
    for (k = 0; k < 2; k++) begin
      cmd_do(CMD_SBYTE_RD);
      chk(resp_d, 64'h78);
      chk_all();
    end
    cmd_do(CMD_EVT_RD);
    chk(resp_d, event_status);
    event_status = 0;
    cmd_do(CMD_SRQ_EN, 0);
    service_request_enable = 0;
    pulse_err(3);
    chk_all();
    cmd_do(CMD_CLS);
    chk(eq_clr, 1'b1);
    event_status = 0;
    chk_all();
    $display("status test done");
    // op-complete: idle sets the done bit again, busy holds it clear
    @(posedge clk);
    mav  <= 1'b0;
    ques <= 16'h0000;
    cmd_do(CMD_OPC);
    @(posedge clk);
    #1;
    event_status = 1;
    chk_all();
    @(posedge clk);
    busy <= 1'b1;
    cmd_do(CMD_OPC);
    event_status = 0;
    repeat (3) @(posedge clk);
    #1;
    chk_all();
    @(posedge clk);
    busy <= 1'b0;
    k = 0;
    while (k < 4 && sb[SB_ESB] !== 1'b1) begin
      @(posedge clk);
      #1;
      k++;
    end
    event_status = 1;
    chk_all();
    $display("op-complete test done");
    // reset command, identity and an unknown code
    cmd_do(CMD_RST);
    set_defaults();
    chk_all();
    cmd_do(CMD_IDN);
    chk(resp_d, {MK, MD, SN, FW});
    cmd_do(cmd_code_t'(5'h1F), 7, 7, 7, 7);
    chk_all();
    $display("reset and identity test done");
    wrap_up();
  end : main

  // hang guard
  initial begin : watchdog
    #(20000 * 25);
    fails++;
    wrap_up();
  end : watchdog
endmodule : list_command_a_status_tb
